// ==== logic/prs_pkg.sv ====
// package: constants and carriers for the reset sequencer
package prs_pkg;
  // ==========================================================
  // timing
  localparam int unsigned CLK_PERIOD_PS   = 5000;
  localparam int unsigned HW_LOW_MIN_CYC  = 5;
  localparam int unsigned EXIT_MAX_NS     = 640;
  // exit budget is counted in reference-clock cycles, not derived from the period
  localparam int unsigned EXIT_CYC        = 16;
  // exit-state length: budget less two sync stages, one filter cycle and one output register
  localparam int unsigned EXIT_HOLD_CYC   = EXIT_CYC - 4;
  localparam int unsigned POR_HOLD_US     = 20;
  localparam int unsigned POR_HOLD_CYC    = (POR_HOLD_US * 1000000) / CLK_PERIOD_PS;
  localparam int unsigned CLK_VALID_MS    = 53;
  localparam int unsigned CLK_VALID_CYC   = (CLK_VALID_MS * 1000000) / (CLK_PERIOD_PS / 1000);
  localparam int unsigned SW_RST_CYC      = 2;
  // ==========================================================
  // field layout
  localparam int unsigned ADDR_W          = 5;
  localparam int unsigned ADDR_LSB        = 6;
  localparam int unsigned SW_RST_BIT      = 15;
  localparam logic [4:0]  ADDR_RST        = 5'h00;
  localparam logic [2:0]  LATCH_RST       = 3'h0;

  typedef enum logic [1:0] {
    PRS_SRC_NONE,
    PRS_SRC_HW,
    PRS_SRC_POR,
    PRS_SRC_SW
  } prs_src_e;

  typedef enum {
    PRS_ST_POR,
    PRS_ST_RESET,
    PRS_ST_EXIT,
    PRS_ST_WAIT_CLK,
    PRS_ST_RUN
  } prs_state_e;

  // entry/exit controls toward the rest of the device
  typedef struct packed {
    logic mac_isolate;
    logic line_tx_oe;
    logic power_down;
    logic modules_en;
    logic regs_default;
    logic pll_resync;
  } prs_ctrl_s;
endpackage : prs_pkg

// ==== logic/prs_reset_seq.sv ====
// reset sequencer: hardware, power-on and software reset of the phy
`timescale 1ns/1ps
module prs_reset_seq #(
  parameter int unsigned POR_CYC   = prs_pkg::POR_HOLD_CYC,
  parameter int unsigned CLKOK_CYC = prs_pkg::CLK_VALID_CYC
) (
  input  wire logic                        clk_sys,
  input  wire logic                        rstn,
  input  wire logic                        hw_reset_pin_n,
  input  wire logic                        sw_reset_wr,
  input  wire logic                        power_down_bit,
  input  wire logic [prs_pkg::ADDR_W-1:0]  phy_addr_pins,
  input  wire logic                        tx_nibble_clock_ok,
  input  wire logic                        rx_nibble_clock_ok,
  output logic                             sw_reset_bit,
  output logic [prs_pkg::ADDR_W-1:0]       phy_addr_field,
  output logic                             mac_out_zero_n,
  output logic                             line_tx_pos_oe,
  output logic                             line_tx_neg_oe,
  output logic                             latch_status_reload,
  output prs_pkg::prs_ctrl_s               ctrl,
  output logic                             mgmt_ready,
  output logic                             reset_done
);
  import prs_pkg::*;

  // ==========================================================
  // pin synchroniser and low filter
  logic       pin_s1_q;
  logic       pin_s2_q;
  logic [2:0] low_cnt_q;
  logic [2:0] low_cnt_d;
  logic       hw_req;

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      pin_s1_q <= 1'b1;
      pin_s2_q <= 1'b1;
    end else begin
      pin_s1_q <= hw_reset_pin_n;
      pin_s2_q <= pin_s1_q;
    end
  end

  // low filter counts only the second stage; the first stage feeds nothing else
  assign low_cnt_d = pin_s2_q ? 3'h0 :
                     (low_cnt_q == 3'(HW_LOW_MIN_CYC)) ? low_cnt_q : low_cnt_q + 3'h1;
  assign hw_req    = (low_cnt_q == 3'(HW_LOW_MIN_CYC));

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      low_cnt_q <= 3'h0;
    end else begin
      low_cnt_q <= low_cnt_d;
    end
  end

  // ==========================================================
  // sequencer
  prs_state_e state_q;
  prs_state_e state_d;
  prs_src_e   src_q;
  prs_src_e   src_d;
  logic [31:0] cnt_q;
  logic [31:0] cnt_d;
  logic        clocks_ok;
  logic        in_reset;
  logic        pd_entry;

  assign clocks_ok = tx_nibble_clock_ok & rx_nibble_clock_ok;

  always_comb begin
    state_d = state_q;
    src_d   = src_q;
    cnt_d   = cnt_q + 32'h1;
    case (state_q)
      PRS_ST_POR: begin
        // pin ignored while power-on reset runs
        if (cnt_q >= 32'(POR_CYC) - 32'h1) begin
          state_d = PRS_ST_EXIT;
          cnt_d   = 32'h0;
        end
      end
      PRS_ST_RESET: begin
        if (src_q == PRS_SRC_SW) begin
          if (cnt_q >= 32'(SW_RST_CYC) - 32'h1) begin
            state_d = PRS_ST_EXIT;
            cnt_d   = 32'h0;
          end
        end else if (hw_req) begin
          cnt_d = 32'h0;
        end else begin
          state_d = PRS_ST_EXIT;
          cnt_d   = 32'h0;
        end
      end
      PRS_ST_EXIT: begin
        // short fixed exit, well inside the 640 ns budget after pin rise
        if (hw_req) begin
          state_d = PRS_ST_RESET;
          src_d   = PRS_SRC_HW;
          cnt_d   = 32'h0;
        end else if (cnt_q >= 32'(EXIT_HOLD_CYC) - 32'h1) begin
          state_d = PRS_ST_WAIT_CLK;
          cnt_d   = 32'h0;
        end
      end
      PRS_ST_WAIT_CLK: begin
        if (hw_req) begin
          state_d = PRS_ST_RESET;
          src_d   = PRS_SRC_HW;
          cnt_d   = 32'h0;
        end else if (clocks_ok || cnt_q >= 32'(CLKOK_CYC)) begin
          state_d = PRS_ST_RUN;
          src_d   = PRS_SRC_NONE;
        end
      end
      default: begin
        cnt_d = 32'h0;
        if (hw_req) begin
          state_d = PRS_ST_RESET;
          src_d   = PRS_SRC_HW;
        end else if (sw_reset_wr) begin
          state_d = PRS_ST_RESET;
          src_d   = PRS_SRC_SW;
        end
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      state_q <= PRS_ST_POR;
      src_q   <= PRS_SRC_POR;
      cnt_q   <= 32'h0;
    end else begin
      state_q <= state_d;
      src_q   <= src_d;
      cnt_q   <= cnt_d;
    end
  end

  // ==========================================================
  // entry and exit actions
  assign in_reset = (state_d == PRS_ST_POR) || (state_d == PRS_ST_RESET);
  // software reset keeps power; explicit power-down bit also powers down
  assign pd_entry = (in_reset && src_d != PRS_SRC_SW) || power_down_bit;

  logic exit_first;
  logic sw_exit;
  assign exit_first = (state_q != PRS_ST_EXIT) && (state_d == PRS_ST_EXIT);
  assign sw_exit    = exit_first && (src_q == PRS_SRC_SW);

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      ctrl                <= '{mac_isolate: 1'b1, line_tx_oe: 1'b0, power_down: 1'b1,
                               modules_en: 1'b0, regs_default: 1'b1, pll_resync: 1'b0};
      mac_out_zero_n      <= 1'b0;
      line_tx_pos_oe      <= 1'b0;
      line_tx_neg_oe      <= 1'b0;
      latch_status_reload <= 1'b1;
      mgmt_ready          <= 1'b0;
      reset_done          <= 1'b0;
    end else begin
      ctrl.mac_isolate    <= in_reset || state_d == PRS_ST_EXIT || pd_entry;
      mac_out_zero_n      <= !(in_reset || state_d == PRS_ST_EXIT || pd_entry);
      line_tx_pos_oe      <= !(in_reset || pd_entry);
      line_tx_neg_oe      <= !(in_reset || pd_entry);
      ctrl.line_tx_oe     <= !(in_reset || pd_entry);
      ctrl.power_down     <= pd_entry;
      ctrl.modules_en     <= !in_reset;
      ctrl.regs_default   <= in_reset || exit_first;
      ctrl.pll_resync     <= exit_first;
      latch_status_reload <= in_reset;
      mgmt_ready          <= (state_d == PRS_ST_WAIT_CLK) || (state_d == PRS_ST_RUN);
      reset_done          <= (state_d == PRS_ST_RUN);
    end
  end

  // ==========================================================
  // address capture and software reset bit
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      phy_addr_field <= ADDR_RST;
      sw_reset_bit   <= 1'b0;
    end else begin
      if (exit_first && !sw_exit) begin
        phy_addr_field <= phy_addr_pins;
      end
      // bit rises only on a software write; defaults on exit clear it
      if (state_q == PRS_ST_RUN && sw_reset_wr && !hw_req) begin
        sw_reset_bit <= 1'b1;
      end else if (exit_first) begin
        sw_reset_bit <= 1'b0;
      end
    end
  end

endmodule : prs_reset_seq

// ==== test/prs_reset_seq_props.sv ====
// checker: port properties of the reset sequencer
`timescale 1ns/1ps
module prs_reset_seq_props (
  input wire logic               clk_sys,
  input wire logic               rstn,
  input wire logic               hw_reset_pin_n,
  input wire logic               sw_reset_wr,
  input wire logic               power_down_bit,
  input wire logic               sw_reset_bit,
  input wire logic [4:0]         phy_addr_field,
  input wire logic               mac_out_zero_n,
  input wire logic               line_tx_pos_oe,
  input wire logic               line_tx_neg_oe,
  input wire logic               latch_status_reload,
  input wire prs_pkg::prs_ctrl_s ctrl,
  input wire logic               mgmt_ready,
  input wire logic               reset_done
);
  // ==========================================================
  // helpers: boot seen, saturating count of sampled pin-low cycles
  logic       boot_q;
  logic [2:0] low_q;
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      boot_q <= 1'b0;
      low_q  <= 3'h0;
    end else begin
      boot_q <= boot_q | mgmt_ready;
      low_q  <= hw_reset_pin_n ? 3'h0 : low_q + {2'h0, low_q != 3'h7};
    end
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  // ==========================================================
  // properties
  sequence s_sw_exit;
    ##2 ctrl.pll_resync && !sw_reset_bit;
  endsequence
  property p_entry;
    $rose(ctrl.mac_isolate) && !power_down_bit |->
      !line_tx_pos_oe && !mac_out_zero_n && latch_status_reload;
  endproperty
  property p_pair;    line_tx_pos_oe == line_tx_neg_oe; endproperty
  property p_hw_min;  $fell(mgmt_ready) |-> sw_reset_bit || power_down_bit || low_q >= 3'h5;
  endproperty
  property p_hw_exit; boot_q && $rose(hw_reset_pin_n) |-> ##[0:16] mgmt_ready; endproperty
  property p_sw_take; reset_done && sw_reset_wr && !sw_reset_bit |=> sw_reset_bit; endproperty
  property p_sw_exit; $rose(sw_reset_bit) |-> s_sw_exit; endproperty
  property p_sw_nopd; sw_reset_bit && !power_down_bit |-> !ctrl.power_down; endproperty
  property p_addr;    $rose(sw_reset_bit) |-> $stable(phy_addr_field) [*8]; endproperty
  property p_por_bit; !boot_q |-> !sw_reset_bit; endproperty
  a_entry:    assert property (p_entry) else $error("reset entry state wrong");
  a_pair:     assert property (p_pair) else $error("transmit pair enables differ");
  a_hw_min:   assert property (p_hw_min) else $error("reset on short pin pulse");
  a_hw_exit:  assert property (p_hw_exit) else $error("hw exit too slow");
  a_sw_take:  assert property (p_sw_take) else $error("sw write not taken");
  a_sw_exit:  assert property (p_sw_exit) else $error("sw reset length wrong");
  a_sw_nopd:  assert property (p_sw_nopd) else $error("sw reset powered down");
  a_addr:     assert property (p_addr) else $error("address changed by sw reset");
  a_por_bit:  assert property (p_por_bit) else $error("sw bit set by power-on");
endmodule : prs_reset_seq_props
bind prs_reset_seq prs_reset_seq_props u_props (.clk_sys, .rstn, .hw_reset_pin_n, .sw_reset_wr,
  .power_down_bit, .sw_reset_bit, .phy_addr_field, .mac_out_zero_n, .line_tx_pos_oe,
  .line_tx_neg_oe, .latch_status_reload, .ctrl, .mgmt_ready, .reset_done);

// ==== test/prs_mac_model.sv ====
// partner: nibble-clock recovery and the mac that waits for it
`timescale 1ns/1ps
module prs_mac_model (
  input  wire logic clk_sys,
  input  wire logic rstn,
  input  wire logic pll_resync,
  input  wire logic reset_done,
  input  wire logic slow,
  output logic      tx_ok,
  output logic      rx_ok,
  output logic      mac_active
);
  // ==========================================================
  // lock counter: clocks invalid until the plls settle after resync
  logic [5:0] lock_q;
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) lock_q <= 6'h08;
    else if (pll_resync) lock_q <= slow ? 6'h28 : 6'h04;
    else lock_q <= lock_q - {5'h0, lock_q != 6'h00};
  end
  assign tx_ok = lock_q == 6'h00;
  assign rx_ok = lock_q <= 6'h01;
  assign mac_active = reset_done & tx_ok & rx_ok;
endmodule : prs_mac_model

// ==== test/test_prs_reset_seq.sv ====
// bench: reset sequencer scenarios
`timescale 1ns/1ps
module test_prs_reset_seq;
  import prs_pkg::*;
  logic       clk_sys, rstn, hw_reset_pin_n, sw_reset_wr, power_down_bit, slow;
  logic [4:0] phy_addr_pins, phy_addr_field;
  logic       tx_nibble_clock_ok, rx_nibble_clock_ok, mac_active, sw_reset_bit;
  logic       mac_out_zero_n, line_tx_pos_oe, line_tx_neg_oe, latch_status_reload;
  logic       mgmt_ready, reset_done;
  prs_ctrl_s  ctrl;
  int         mismatches = 0, cmp_count = 0, cyc = 0, n;
  prs_reset_seq #(.POR_CYC(10), .CLKOK_CYC(50)) dut (.clk_sys, .rstn, .hw_reset_pin_n,
    .sw_reset_wr, .power_down_bit, .phy_addr_pins, .tx_nibble_clock_ok, .rx_nibble_clock_ok,
    .sw_reset_bit, .phy_addr_field, .mac_out_zero_n, .line_tx_pos_oe, .line_tx_neg_oe,
    .latch_status_reload, .ctrl, .mgmt_ready, .reset_done);
  prs_mac_model u_mac (.clk_sys, .rstn, .pll_resync(ctrl.pll_resync), .reset_done, .slow,
    .tx_ok(tx_nibble_clock_ok), .rx_ok(rx_nibble_clock_ok), .mac_active);
  // ==========================================================
  // tasks
  task automatic chk(input logic [4:0] seen, input logic [4:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic conclude();
    if (mismatches == 0 && cmp_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : conclude
  // bounded wait: 0 ready, 1 done, 2 sw bit clear; n counts cycles
  task automatic wait_on(input int sel, input int lim);
    n = 0;
    while (!(sel == 0 ? mgmt_ready === 1'b1 : sel == 1 ? reset_done === 1'b1
             : sw_reset_bit === 1'b0) && n < lim) begin
      @(negedge clk_sys);
      n++;
    end
  endtask : wait_on
  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 3000) begin
      mismatches++;
      conclude();
    end
  end
  // ==========================================================
  // scenarios
  initial begin
    {rstn, sw_reset_wr, power_down_bit, slow} = 4'h0;
    hw_reset_pin_n = 1'b1;
    phy_addr_pins  = 5'h15;
    repeat (3) @(negedge clk_sys);
    rstn = 1'b1;
    wait_on(1, 200);
    chk(phy_addr_field, 5'h15);
    chk({sw_reset_bit, ctrl.power_down, ctrl.modules_en, line_tx_pos_oe, ctrl.line_tx_oe},
        5'h07);
    chk(ctrl.regs_default, 1'b0);
    chk(mac_active, 1'b1);
    hw_reset_pin_n = 1'b0;
    repeat (3) @(negedge clk_sys);
    hw_reset_pin_n = 1'b1;
    repeat (10) @(negedge clk_sys);
    chk(mgmt_ready, 1'b1);
    phy_addr_pins  = 5'h0a;
    hw_reset_pin_n = 1'b0;
    repeat (9) @(negedge clk_sys);
    chk({ctrl.mac_isolate, line_tx_pos_oe, ctrl.power_down, latch_status_reload, mac_out_zero_n},
        5'h16);
    chk({ctrl.regs_default, ctrl.line_tx_oe, ctrl.modules_en}, 5'h04);
    hw_reset_pin_n = 1'b1;
    wait_on(0, 40);
    chk(n <= 16, 1'b1);
    chk(phy_addr_field, 5'h0a);
    wait_on(1, 100);
    chk(reset_done, 1'b1);
    phy_addr_pins = 5'h03;
    slow          = 1'b1;
    sw_reset_wr   = 1'b1;
    @(negedge clk_sys);
    sw_reset_wr = 1'b0;
    @(negedge clk_sys);
    chk({sw_reset_bit, ctrl.power_down, ctrl.mac_isolate}, 5'h05);
    wait_on(2, 10);
    chk(n <= 2, 1'b1);
    wait_on(1, 100);
    chk(reset_done, 1'b1);
    chk(phy_addr_field, 5'h0a);
    power_down_bit = 1'b1;
    repeat (4) @(negedge clk_sys);
    chk({mac_out_zero_n, line_tx_neg_oe}, 5'h00);
    power_down_bit = 1'b0;
    conclude();
  end
endmodule : test_prs_reset_seq
